/* src/smcc_mode_flag.v */
// Sticky mode flag, set by its command and cleared only by reset
`timescale 1ns/1ps
module smcc_mode_flag
(
  input wire clk_sys_i,
  input wire clr_i,
  input wire set_i,
  output wire flag_o,
  output wire ignored_o
);
  reg flag_reg;
  // Set once, held until reset; repeats are ignored
  always @(posedge clk_sys_i)
  begin
    if (clr_i)
      flag_reg <= 1'b0;
    else if (set_i)
      flag_reg <= 1'b1;
  end
  assign flag_o = flag_reg;
  assign ignored_o = set_i & flag_reg;
endmodule // smcc_mode_flag

/* src/smcc_regs.vh */
// Constants for the scan mode command control block
`ifndef SMCC_REGS_VH
`define SMCC_REGS_VH
// Command opcodes
`define SMCC_OP_NOP 4'h0
`define SMCC_OP_SOFT_RESET 4'h1
`define SMCC_OP_FAULT_QUERY 4'h2
`define SMCC_OP_REV_QUERY 4'h3
`define SMCC_OP_FAST_SCAN 4'h4
`define SMCC_OP_FIFTY_HZ 4'h5
// Response kinds
`define SMCC_RSP_FAULT 2'h1
`define SMCC_RSP_REV 2'h2
`define SMCC_RSP_ERR 2'h3
// Timing in microseconds, as printed
`define SMCC_SLOT_DEF_US 22000
`define SMCC_SLOT_FAST_US 9000
`define SMCC_INTEG_60_US 16700
`define SMCC_INTEG_50_US 20000
// Clock rate in MHz
`define SMCC_CLK_MHZ 100
// Flag reset values
`define SMCC_FAST_RST 1'b0
`define SMCC_FIFTY_RST 1'b0
`endif

/* src/smcc_top.v */
// Command interpreter for scan mode, revision and fault queries
`timescale 1ns/1ps
`include "smcc_regs.vh"
module smcc_top
#(
  parameter NUM_CHAN = 8,
  parameter FAULT_W = 8,
  parameter [15:0] REV_SCALED = 16'h0064,
  parameter [31:0] SLOT_DEF_CYC = `SMCC_SLOT_DEF_US * `SMCC_CLK_MHZ,
  parameter [31:0] SLOT_FAST_CYC = `SMCC_SLOT_FAST_US * `SMCC_CLK_MHZ,
  parameter [31:0] INTEG_60_CYC = `SMCC_INTEG_60_US * `SMCC_CLK_MHZ,
  parameter [31:0] INTEG_50_CYC = `SMCC_INTEG_50_US * `SMCC_CLK_MHZ
)
(
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire cmd_valid_i,
  input wire [3:0] cmd_op_i,
  input wire [3:0] cmd_chan_i,
  input wire [FAULT_W-1:0] fault_i,
  output wire cmd_ready_o,
  output reg rsp_valid_o,
  output reg [1:0] rsp_kind_o,
  output reg [15:0] rsp_data_o,
  output wire fast_scan_o,
  output wire fifty_hz_o,
  output reg [31:0] slot_cycles_o,
  output reg [31:0] integ_cycles_o,
  output reg slot_tick_o,
  output wire soft_reset_o,
  output wire [FAULT_W-1:0] fault_status_word_o
);
  wire cmd_fire;
  wire soft_rst;
  wire clr_all;
  wire fast_set;
  wire fifty_set;
  wire chan_ok;
  wire [15:0] fault_ext;
  reg [FAULT_W-1:0] fault_reg;
  reg [31:0] slot_cnt_reg;

  // Command decode
  // The block never stalls the client: every strobe is a taken command.
  // Back-to-back commands are legal, one per clock.
  // Opcodes outside the known set still produce an error answer,
  // so the client always learns that its command was not understood.
  // Always ready: each command is executed in the cycle it is taken
  assign cmd_ready_o = 1'b1;
  assign cmd_fire = cmd_valid_i;
  assign soft_rst = cmd_fire & (cmd_op_i == `SMCC_OP_SOFT_RESET);
  // Hard and soft reset clear identical state, nothing outside
  // One shared clear keeps the two reset paths from drifting apart:
  // any new state added later is cleared by both without extra work.
  // The soft reset pulse is also handed out on a port, so that
  // neighbouring logic of this unit only can follow it; other boards
  // of the system never see it.
  assign clr_all = ~rst_n_i | soft_rst;
  assign soft_reset_o = soft_rst;
  assign fast_set = cmd_fire & (cmd_op_i == `SMCC_OP_FAST_SCAN);
  assign fifty_set = cmd_fire & (cmd_op_i == `SMCC_OP_FIFTY_HZ);
  // Zero-based channel check against the variant size
  // Eight-channel variant accepts 0 to 7, sixteen-channel 0 to 15.
  // The extra top bit keeps the compare from wrapping at sixteen.
  assign chan_ok = ({1'b0, cmd_chan_i} < NUM_CHAN[4:0]);

  // Independent sticky mode flags
  // Each flag only ever goes up on its own command and only ever
  // comes down on a reset; a repeated command finds the flag already
  // set and changes nothing. The ignore indication is left open here,
  // since the command answers nothing for these two opcodes.
  smcc_mode_flag u_fast_flag
  (
    .clk_sys_i(clk_sys_i),
    .clr_i(clr_all),
    .set_i(fast_set),
    .flag_o(fast_scan_o),
    .ignored_o()
  );
  smcc_mode_flag u_fifty_flag
  (
    .clk_sys_i(clk_sys_i),
    .clr_i(clr_all),
    .set_i(fifty_set),
    .flag_o(fifty_hz_o),
    .ignored_o()
  );

  // Timing selected by the mode flags
  // Slot length and integration period are registered so the timer
  // below sees a clean value one clock after a mode change.
  // Fast scan selects the short slot; fifty hertz the long integration.
  // Both fall back to their defaults on any reset, never otherwise.
  always @(posedge clk_sys_i)
  begin
    if (clr_all)
    begin
      slot_cycles_o <= SLOT_DEF_CYC;
      integ_cycles_o <= INTEG_60_CYC;
    end
    else
    begin
      slot_cycles_o <= fast_scan_o ? SLOT_FAST_CYC : SLOT_DEF_CYC;
      integ_cycles_o <= fifty_hz_o ? INTEG_50_CYC : INTEG_60_CYC;
    end
  end

  // Slot timer pulses once per channel slot
  // The counter runs from zero to one less than the slot length and
  // then wraps, so ticks are exactly slot_cycles_o clocks apart.
  // A change to a shorter slot while the count is already past the
  // new end wraps at once rather than running through all 32 bits.
  always @(posedge clk_sys_i)
  begin
    if (clr_all)
    begin
      slot_cnt_reg <= 32'h0000_0000;
      slot_tick_o <= 1'b0;
    end
    else if (slot_cnt_reg + 32'h0000_0001 >= slot_cycles_o)
    begin
      slot_cnt_reg <= 32'h0000_0000;
      slot_tick_o <= 1'b1;
    end
    else
    begin
      slot_cnt_reg <= slot_cnt_reg + 32'h0000_0001;
      slot_tick_o <= 1'b0;
    end
  end

  // Hardware fault status register follows fault inputs
  // This is a live copy, one clock behind the fault lines, not a
  // sticky log: a fault that goes away also leaves the register.
  // A soft reset clears it for one clock, a hard reset for as long as rst_n_i is low, before it picks the lines up again.
  always @(posedge clk_sys_i)
  begin
    if (clr_all)
      fault_reg <= {FAULT_W{1'b0}};
    else
      fault_reg <= fault_i;
  end
  assign fault_status_word_o = fault_reg;
  assign fault_ext = {{(16-FAULT_W){1'b0}}, fault_reg};

  // Zero extension of the fault word to the answer width
  // Answers for data-producing commands, one cycle after taking
  // Valid is a one-clock pulse; kind and data hold until the next
  // answer so a slow reader still sees the last one.
  // Mode commands, nop and soft reset produce no answer at all.
  // Unknown opcodes answer with the opcode and the channel check
  // so the client can tell a bad opcode from a bad channel number.
  always @(posedge clk_sys_i)
  begin
    if (clr_all)
    begin
      rsp_valid_o <= 1'b0;
      rsp_kind_o <= 2'h0;
      rsp_data_o <= 16'h0000;
    end
    else
    begin
      rsp_valid_o <= 1'b0;
      if (cmd_fire)
      begin
        case (cmd_op_i)
          `SMCC_OP_FAULT_QUERY:
          begin
            rsp_valid_o <= 1'b1;
            rsp_kind_o <= `SMCC_RSP_FAULT;
            rsp_data_o <= fault_ext;
          end
          `SMCC_OP_REV_QUERY:
          begin
            rsp_valid_o <= 1'b1;
            rsp_kind_o <= `SMCC_RSP_REV;
            rsp_data_o <= REV_SCALED;
          end
          `SMCC_OP_NOP, `SMCC_OP_FAST_SCAN, `SMCC_OP_FIFTY_HZ:
          begin
            rsp_valid_o <= 1'b0;
          end
          default:
          begin
            rsp_valid_o <= 1'b1;
            rsp_kind_o <= `SMCC_RSP_ERR;
            rsp_data_o <= {11'h000, chan_ok, cmd_op_i};
          end
        endcase
      end
    end
  end
endmodule // smcc_top

/* testbench/smcc_host.sv */
// Client host model issuing commands
`timescale 1ns/1ps
module smcc_host
(
  input wire clk_sys_i,
  output reg cmd_valid_o = 1'b0,
  output reg [3:0] cmd_op_o = 4'h0,
  output reg [3:0] cmd_chan_o = 4'h0
);
  // One command per call; released lines show the inverse
  task issue(input [3:0] op, input [3:0] ch);
    @(posedge clk_sys_i);
    cmd_valid_o <= 1'b1;
    cmd_op_o <= op;
    cmd_chan_o <= ch;
    @(posedge clk_sys_i);
    cmd_valid_o <= 1'b0;
    cmd_op_o <= ~op;
    cmd_chan_o <= ~ch;
  endtask
endmodule // smcc_host

/* testbench/smcc_top_chk.sv */
// Port checker for scan mode command control
`timescale 1ns/1ps
module smcc_chk #(parameter NUM_CHAN = 8, parameter [15:0] REV_SCALED = 16'h0064,
  parameter [31:0] SLOT_DEF_CYC = 1, SLOT_FAST_CYC = 1, INTEG_60_CYC = 1, INTEG_50_CYC = 1)
(
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire cmd_valid_i,
  input wire [3:0] cmd_op_i,
  input wire [3:0] cmd_chan_i,
  input wire rsp_valid_o,
  input wire [1:0] rsp_kind_o,
  input wire [15:0] rsp_data_o,
  input wire fast_scan_o,
  input wire fifty_hz_o,
  input wire [31:0] slot_cycles_o,
  input wire [31:0] integ_cycles_o,
  input wire soft_reset_o
);
  // Opcode taken at this edge, nop when idle
  wire [3:0] o = cmd_valid_i ? cmd_op_i : 4'h0;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  AST_REV: assert property (o == 4'h3 |=> rsp_kind_o == 2'h2 && rsp_data_o == REV_SCALED)
    else $error("revision answer wrong");
  AST_ERR: assert property (o > 4'h5 |=> rsp_kind_o == 2'h3
    && rsp_data_o == {11'h000, $past(cmd_chan_i) < NUM_CHAN, $past(o)}) else $error("error answer");
  AST_RSP: assert property (o == 4'h2 || o == 4'h3 || o > 4'h5 |=> rsp_valid_o)
    else $error("answer missing");
  AST_NORSP: assert property (o < 4'h2 || o == 4'h4 || o == 4'h5 |=> !rsp_valid_o)
    else $error("answer unexpected");
  AST_FAST: assert property (o == 4'h4 |=> fast_scan_o) else $error("fast not set");
  AST_SLOT: assert property (o != 4'h1 |=>
    slot_cycles_o == ($past(fast_scan_o) ? SLOT_FAST_CYC : SLOT_DEF_CYC)) else $error("slot");
  AST_INTEG: assert property (o != 4'h1 |=>
    integ_cycles_o == ($past(fifty_hz_o) ? INTEG_50_CYC : INTEG_60_CYC)) else $error("integ");
  AST_KEEP: assert property (fast_scan_o && o != 4'h1 |=> fast_scan_o)
    else $error("fast lost");
  AST_KEEP50: assert property (fifty_hz_o && o != 4'h1 |=> fifty_hz_o)
    else $error("fifty lost");
  AST_SOFT: assert property (o == 4'h1 |-> soft_reset_o ##1 !fast_scan_o && !fifty_hz_o)
    else $error("soft reset");
endmodule // smcc_chk
bind smcc_top smcc_chk #(.NUM_CHAN(NUM_CHAN), .REV_SCALED(REV_SCALED), .SLOT_DEF_CYC(SLOT_DEF_CYC),
  .SLOT_FAST_CYC(SLOT_FAST_CYC), .INTEG_60_CYC(INTEG_60_CYC), .INTEG_50_CYC(INTEG_50_CYC)) u_chk (.*);

/* testbench/test_scan_mode_command_control.sv */
// Self-checking bench for scan mode command control
`timescale 1ns/1ps
module test_scan_mode_command_control;
  reg clk_sys_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [7:0] fault_i = 8'h00;
  wire cv, rv, fs, ff, tk;
  wire [3:0] op, ch;
  wire [1:0] kd;
  wire [15:0] dt;
  wire [31:0] sl, ig;
  wire [7:0] fw;
  integer n_fail = 0;
  integer num_checks = 0;
  // Clock and watchdog
  always #5 clk_sys_i = ~clk_sys_i;
  initial
  begin
    #100000 n_fail = n_fail + 1;
    summarize;
  end
  smcc_host host (.clk_sys_i(clk_sys_i), .cmd_valid_o(cv), .cmd_op_o(op), .cmd_chan_o(ch));
  smcc_top #(.SLOT_DEF_CYC(20), .SLOT_FAST_CYC(9), .INTEG_60_CYC(16), .INTEG_50_CYC(20)) dut
    (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cmd_valid_i(cv), .cmd_op_i(op), .cmd_chan_i(ch),
    .fault_i(fault_i), .cmd_ready_o(), .rsp_valid_o(rv), .rsp_kind_o(kd), .rsp_data_o(dt),
    .fast_scan_o(fs), .fifty_hz_o(ff), .slot_cycles_o(sl), .integ_cycles_o(ig),
    .slot_tick_o(tk), .soft_reset_o(), .fault_status_word_o(fw));
  // Compare and verdict
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    num_checks = num_checks + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("BAD %0s exp %h got %h", nm, e, g);
    end
  endtask
  task summarize;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Clocks between two slot ticks, bounded waits
  task t_tick(input [31:0] per);
    integer k;
    integer gap;
    begin
      gap = 0;
      for (k = 0; k < 64 && tk !== 1'b1; k = k + 1)
        @(posedge clk_sys_i) #1;
      for (k = 0; k < 64 && (gap == 0 || tk !== 1'b1); k = k + 1)
      begin
        @(posedge clk_sys_i) #1;
        gap = gap + 1;
      end
      chk("tick", per, gap);
    end
  endtask
  // Answers packed as valid, kind, data
  task t_query;
    @(posedge clk_sys_i) fault_i <= 8'h5a;
    host.issue(4'h3, 4'h0);
    #1 chk("rev", 32'h0006_0064, {rv, kd, dt});
    host.issue(4'h2, 4'h0);
    #1 chk("fault", 32'h0005_005a, {rv, kd, dt});
    host.issue(4'h7, 4'h9);
    #1 chk("err", 32'h0007_0007, {rv, kd, dt});
    host.issue(4'hf, 4'h7);
    #1 chk("err", 32'h0007_001f, {rv, kd, dt});
  endtask
  // Both modes set, repeated, then a nop
  task t_modes;
    #1 chk("slot", 32'h0000_0014, sl);
    host.issue(4'h4, 4'h0);
    host.issue(4'h4, 4'h0);
    host.issue(4'h5, 4'h0);
    host.issue(4'h5, 4'h0);
    host.issue(4'h0, 4'h0);
    #1 chk("slot", 32'h0000_0009, sl);
    chk("integ", 32'h0000_0014, ig);
    chk("flags", 32'h0000_0006, {fs, ff, rv});
  endtask
  // Soft then hard reset restore defaults
  task t_resets;
    host.issue(4'h1, 4'h0);
    #1 chk("soft", 32'h0000_0000, {fs, ff, rv});
    @(posedge clk_sys_i) #1 chk("dflt", 32'h0014_0010, {sl[15:0], ig[15:0]});
    host.issue(4'h4, 4'h0);
    rst_n_i <= 1'b0;
    @(posedge clk_sys_i) #1 chk("hard", 32'h0000_0000, {fs, fw});
    @(posedge clk_sys_i) rst_n_i <= 1'b1;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_query;
    t_tick(32'h0000_0014);
    t_modes;
    t_tick(32'h0000_0009);
    t_resets;
    t_modes;
    summarize;
  end
endmodule // test_scan_mode_command_control
